// File: rtl/current_fault_response_ctrl.sv
// undercurrent fault response controller with its management bus command port
//
// Operation
// - command 0xe6 is a read/write byte that configures the undercurrent fault response.
// - in every response mode a fault pulls the alert line low and sets the fault status bit.
// - the status bit set is the undercurrent bit, not a voltage or temperature bit.
// - response 00 keeps the output running untouched while the fault lasts.
// - response 01 keeps running for the delay in bits 2:0, then follows the retry field if the fault remains.
// - response 10 disables the output at once and then follows the retry field.
// - response 11 holds the output off only while the fault lasts and re-enables it when it goes.
// - the retry field in bits 5:3 sets how many restart attempts follow a fault shutdown.
// - retry 000 makes no attempt and keeps the output off until the fault is cleared.
// - retry 111 retries without limit until commanded off, power is lost or another fault shuts down.
// - bits 2:0 are a count 0 to 7, in 10 ms units when used as the continue-operating time.
// - the same count is in 8.2 ms units when used as the spacing between restart attempts.
// - retry 001 to 110 allow one to six attempts, after which the output stays off until cleared.
module current_fault_response_ctrl #(
  parameter logic [6:0] DEV_ADDR          = uc_fault_pkg::DEV_ADDR_DEFAULT,
  parameter int         CONT_UNIT_CYCLES  = uc_fault_pkg::CONT_UNIT_CYCLES,
  parameter int         RETRY_UNIT_CYCLES = uc_fault_pkg::RETRY_UNIT_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // management bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  // alert pin, open drain
  output logic      alert_out_n_o,
  output logic      alert_out_n_oe_n_o,
  // power stage
  input  wire logic uc_fault_i,
  input  wire logic output_on_i,
  input  wire logic other_fault_i,
  output logic      output_enable_o
);

  localparam int TW = uc_fault_pkg::TIMER_WIDTH;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (CONT_UNIT_CYCLES < 1 || CONT_UNIT_CYCLES >= (1 << TW)) begin : g_bad_cont
    $error("continue unit does not fit the timer");
  end
  if (RETRY_UNIT_CYCLES < 1 || RETRY_UNIT_CYCLES >= (1 << TW)) begin : g_bad_retry
    $error("retry unit does not fit the timer");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] sync_w;
  logic       scl_s;
  logic       sda_s;
  logic       fault_s;
  logic       on_s;
  logic       other_s;

  pin_sync #(
    .WIDTH      (uc_fault_pkg::SYNC_WIDTH),
    .RESET_BITS (4'h3)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({other_fault_i, uc_fault_i, sda_i, scl_i}),
    .sync_o  (sync_w)
  );

  assign scl_s = sync_w[0];
  assign sda_s = sync_w[1];
  assign fault_s = sync_w[2];
  assign on_s = output_on_i;
  assign other_s = sync_w[3];

  // output_on_i crosses too; it gets its own pair to keep sync_w to the bus and fault group
  logic on_meta_q;
  logic on_hold_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      on_meta_q <= 1'b0;
      on_hold_q <= 1'b0;
    end else begin
      on_meta_q <= on_s;
      on_hold_q <= on_meta_q;
    end
  end

  // ----------------------------------------
  // bus edge and condition detection
  // ----------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise_w = scl_s & ~scl_prev_q;
  assign scl_fall_w = ~scl_s & scl_prev_q;
  assign start_w = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_w = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  uc_fault_pkg::uc_response_type resp_q;
  logic                          status_uc_q;
  logic [7:0]                    cmd_q;
  logic [7:0]                    rd_data_w;
  logic                          cmd_known_w;

  assign cmd_known_w = (cmd_q == uc_fault_pkg::CMD_UC_RESPONSE) | (cmd_q == uc_fault_pkg::CMD_STATUS_IOUT);
  assign rd_data_w = (cmd_q == uc_fault_pkg::CMD_UC_RESPONSE) ? resp_q :
                     (cmd_q == uc_fault_pkg::CMD_STATUS_IOUT) ? 8'(status_uc_q) << uc_fault_pkg::STATUS_UC_BIT :
                     8'hff;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  uc_fault_pkg::bus_state_type bus_q;
  logic [7:0]                  shift_q;
  logic [7:0]                  tx_q;
  logic [2:0]                  bit_q;
  logic [1:0]                  byte_q;
  logic                        got_q;
  logic                        tx_next_q;
  logic                        nack_q;
  logic                        sda_oe_n_q;
  logic                        wr_resp_w;
  logic                        wr_status_w;
  logic                        addr_ok_w;
  logic                        ack_w;

  assign addr_ok_w = (shift_q[7:1] == DEV_ADDR);
  assign ack_w = (byte_q == 2'h0) ? addr_ok_w :
                 (byte_q == 2'h1) ? (shift_q == uc_fault_pkg::CMD_UC_RESPONSE) |
                                    (shift_q == uc_fault_pkg::CMD_STATUS_IOUT) :
                 (byte_q == 2'h2) ? cmd_known_w : 1'b0;
  assign wr_resp_w = (bus_q == uc_fault_pkg::B_RX) & got_q & scl_fall_w & (byte_q == 2'h2) &
                     (cmd_q == uc_fault_pkg::CMD_UC_RESPONSE);
  assign wr_status_w = (bus_q == uc_fault_pkg::B_RX) & got_q & scl_fall_w & (byte_q == 2'h2) &
                       (cmd_q == uc_fault_pkg::CMD_STATUS_IOUT) & shift_q[uc_fault_pkg::STATUS_UC_BIT];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_q      <= uc_fault_pkg::B_IDLE;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      bit_q      <= 3'h0;
      byte_q     <= 2'h0;
      got_q      <= 1'b0;
      tx_next_q  <= 1'b0;
      nack_q     <= 1'b0;
      sda_oe_n_q <= 1'b1;
      cmd_q      <= 8'h00;
    end else if (start_w) begin
      bus_q      <= uc_fault_pkg::B_RX;
      bit_q      <= 3'h0;
      byte_q     <= 2'h0;
      got_q      <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_w) begin
      bus_q      <= uc_fault_pkg::B_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (bus_q)
        uc_fault_pkg::B_RX: begin
          if (scl_rise_w) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q   <= bit_q + 3'h1;
            got_q   <= (bit_q == 3'h7);
          end else if (scl_fall_w && got_q) begin
            got_q      <= 1'b0;
            tx_next_q  <= (byte_q == 2'h0) & shift_q[0];
            sda_oe_n_q <= ~ack_w;
            bus_q      <= ack_w ? uc_fault_pkg::B_ACK : uc_fault_pkg::B_IDLE;
            if (byte_q == 2'h1) begin
              cmd_q <= shift_q;
            end
            if (byte_q != 2'h3) begin
              byte_q <= byte_q + 2'h1;
            end
          end
        end
        uc_fault_pkg::B_ACK: begin
          if (scl_fall_w && tx_next_q) begin
            tx_q       <= rd_data_w;
            sda_oe_n_q <= rd_data_w[7];
            bit_q      <= 3'h0;
            bus_q      <= uc_fault_pkg::B_TX;
          end else if (scl_fall_w) begin
            sda_oe_n_q <= 1'b1;
            bit_q      <= 3'h0;
            bus_q      <= uc_fault_pkg::B_RX;
          end
        end
        uc_fault_pkg::B_TX: begin
          if (scl_fall_w && bit_q == 3'h7) begin
            sda_oe_n_q <= 1'b1;
            bus_q      <= uc_fault_pkg::B_RACK;
          end else if (scl_fall_w) begin
            tx_q       <= {tx_q[6:0], 1'b0};
            sda_oe_n_q <= tx_q[6];
            bit_q      <= bit_q + 3'h1;
          end
        end
        uc_fault_pkg::B_RACK: begin
          if (scl_rise_w) begin
            nack_q <= sda_s;
          end else if (scl_fall_w && nack_q) begin
            bus_q <= uc_fault_pkg::B_IDLE;
          end else if (scl_fall_w) begin
            // master asked for more: the same byte is sent again
            tx_q       <= rd_data_w;
            sda_oe_n_q <= rd_data_w[7];
            bit_q      <= 3'h0;
            bus_q      <= uc_fault_pkg::B_TX;
          end
        end
        default: begin
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // response register and undercurrent status
  // ----------------------------------------
  logic fault_prev_q;
  logic fault_rise_w;

  assign fault_rise_w = fault_s & ~fault_prev_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      resp_q       <= uc_fault_pkg::UC_RESPONSE_RESET;
      status_uc_q  <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      fault_prev_q <= fault_s;
      if (wr_resp_w) begin
        resp_q <= shift_q;
      end
      // a new fault wins over a clear in the same cycle
      if (fault_rise_w) begin
        status_uc_q <= 1'b1;
      end else if (wr_status_w) begin
        status_uc_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // fault response state machine
  // ----------------------------------------
  uc_fault_pkg::fault_state_type fst_q;
  uc_fault_pkg::fault_state_type fst_d;
  logic [2:0]                    tries_q;
  logic [2:0]                    tries_d;
  logic                          timer_start_w;
  logic                          timer_cont_w;
  logic                          timer_done_w;
  logic                          give_up_w;
  logic [TW-1:0]                 period_w;

  // retries exhausted or never allowed; 111 never runs out
  assign give_up_w = (resp_q.retries == uc_fault_pkg::RETRY_NONE) |
                     ((resp_q.retries != uc_fault_pkg::RETRY_FOREVER) & (tries_q >= resp_q.retries));

  always_comb begin
    fst_d = fst_q;
    tries_d = tries_q;
    timer_start_w = 1'b0;
    timer_cont_w = 1'b0;
    case (fst_q)
      uc_fault_pkg::F_RUN: begin
        if (fault_s) begin
          case (resp_q.mode)
            uc_fault_pkg::MODE_DELAY_RETRY: begin
              fst_d = uc_fault_pkg::F_DELAY;
              timer_start_w = 1'b1;
              timer_cont_w = 1'b1;
            end
            uc_fault_pkg::MODE_DISABLE_RETRY: begin
              fst_d = give_up_w ? uc_fault_pkg::F_LATCH : uc_fault_pkg::F_OFF_WAIT;
              timer_start_w = ~give_up_w;
            end
            uc_fault_pkg::MODE_HOLD_OFF: fst_d = uc_fault_pkg::F_HOLD;
            default: fst_d = uc_fault_pkg::F_RUN;
          endcase
        end
      end
      uc_fault_pkg::F_DELAY: begin
        if (!fault_s) begin
          fst_d = uc_fault_pkg::F_RUN;
        end else if (timer_done_w) begin
          fst_d = give_up_w ? uc_fault_pkg::F_LATCH : uc_fault_pkg::F_OFF_WAIT;
          timer_start_w = ~give_up_w;
        end
      end
      uc_fault_pkg::F_OFF_WAIT: begin
        if (other_s) begin
          fst_d = uc_fault_pkg::F_LATCH;
        end else if (timer_done_w) begin
          fst_d = uc_fault_pkg::F_RUN;
          tries_d = (tries_q == 3'h7) ? tries_q : tries_q + 3'h1;
        end
      end
      uc_fault_pkg::F_HOLD: begin
        if (!fault_s) begin
          fst_d = uc_fault_pkg::F_RUN;
        end
      end
      uc_fault_pkg::F_LATCH: begin
        if (wr_status_w && !fault_s) begin
          fst_d = uc_fault_pkg::F_RUN;
          tries_d = 3'h0;
        end
      end
      default: fst_d = uc_fault_pkg::F_RUN;
    endcase
    if (!on_hold_q) begin
      // commanded off ends any retry sequence
      fst_d = uc_fault_pkg::F_RUN;
      tries_d = 3'h0;
      timer_start_w = 1'b0;
    end
  end

  // the timer reloads its period every unit, so the continue unit must stand for the whole delay
  assign period_w = (timer_cont_w | ((fst_q == uc_fault_pkg::F_DELAY) & ~timer_start_w)) ?
                    TW'(CONT_UNIT_CYCLES) : TW'(RETRY_UNIT_CYCLES);

  unit_timer #(
    .WIDTH (TW)
  ) u_timer (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .start_i  (timer_start_w),
    .units_i  (resp_q.delay),
    .period_i (period_w),
    .done_o   (timer_done_w)
  );

  // ----------------------------------------
  // state and output flops
  // ----------------------------------------
  logic out_en_q;
  logic alert_oe_n_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fst_q        <= uc_fault_pkg::F_RUN;
      tries_q      <= 3'h0;
      out_en_q     <= 1'b0;
      alert_oe_n_q <= 1'b1;
    end else begin
      fst_q        <= fst_d;
      tries_q      <= tries_d;
      out_en_q     <= on_hold_q & ((fst_d == uc_fault_pkg::F_RUN) | (fst_d == uc_fault_pkg::F_DELAY));
      alert_oe_n_q <= ~(status_uc_q | fault_rise_w);
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = sda_oe_n_q;
  assign alert_out_n_o = 1'b0;
  assign alert_out_n_oe_n_o = alert_oe_n_q;
  assign output_enable_o = out_en_q;

endmodule // current_fault_response_ctrl

// File: rtl/uc_fault_pkg.sv
// package: constants, types and state codes for the undercurrent fault response controller
package uc_fault_pkg;

  // ----------------------------------------
  // command codes and register layout
  // ----------------------------------------
  localparam logic [7:0] CMD_UC_RESPONSE   = 8'he6;
  localparam logic [7:0] CMD_STATUS_IOUT   = 8'h7b;
  localparam logic [7:0] UC_RESPONSE_RESET = 8'h00;
  localparam int         STATUS_UC_BIT     = 4;
  localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h40;

  // ----------------------------------------
  // field values
  // ----------------------------------------
  localparam logic [1:0] MODE_IGNORE        = 2'h0;
  localparam logic [1:0] MODE_DELAY_RETRY   = 2'h1;
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] MODE_HOLD_OFF      = 2'h3;
  localparam logic [2:0] RETRY_NONE         = 3'h0;
  localparam logic [2:0] RETRY_FOREVER      = 3'h7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ            = 100;
  localparam int CONT_UNIT_US       = 10000;
  localparam int RETRY_UNIT_US      = 8200;
  localparam int CONT_UNIT_CYCLES   = CONT_UNIT_US * CLK_MHZ;
  localparam int RETRY_UNIT_CYCLES  = RETRY_UNIT_US * CLK_MHZ;
  localparam int TIMER_WIDTH        = 20;
  localparam int SYNC_WIDTH         = 4;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] retries;
    logic [2:0] delay;
  } uc_response_type;

  typedef enum logic [4:0] {
    F_RUN      = 5'h01,
    F_DELAY    = 5'h02,
    F_OFF_WAIT = 5'h04,
    F_HOLD     = 5'h08,
    F_LATCH    = 5'h10
  } fault_state_type;

  typedef enum logic [4:0] {
    B_IDLE = 5'h01,
    B_RX   = 5'h02,
    B_ACK  = 5'h04,
    B_TX   = 5'h08,
    B_RACK = 5'h10
  } bus_state_type;

endpackage : uc_fault_pkg

// File: rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int                    WIDTH      = 4,
  parameter logic [WIDTH-1:0]      RESET_BITS = '0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ----------------------------------------
  // per bit two stages, first stage feeds only the second
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic hold_q;
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        meta_q <= RESET_BITS[i];
        hold_q <= RESET_BITS[i];
      end else begin
        meta_q <= async_i[i];
        hold_q <= meta_q;
      end
    end
    assign sync_o[i] = hold_q;
  end

endmodule // pin_sync

// File: rtl/unit_timer.sv
// counts a number of time units of a given length in clock cycles
module unit_timer #(
  parameter int WIDTH = 20
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // control
  input  wire logic             start_i,
  input  wire logic [2:0]       units_i,
  input  wire logic [WIDTH-1:0] period_i,
  // result
  output logic                  done_o
);

  logic             busy_q;
  logic [2:0]       unit_q;
  logic [WIDTH-1:0] cyc_q;
  logic             done_q;

  // ----------------------------------------
  // down counters; a restart while busy begins afresh
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      unit_q <= 3'h0;
      cyc_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i) begin
        busy_q <= 1'b1;
        unit_q <= units_i;
        cyc_q  <= period_i - 1'b1;
      end else if (busy_q && unit_q == 3'h0) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (busy_q && cyc_q == '0) begin
        unit_q <= unit_q - 3'h1;
        cyc_q  <= period_i - 1'b1;
      end else if (busy_q) begin
        cyc_q <= cyc_q - 1'b1;
      end
    end
  end

  assign done_o = done_q;

endmodule // unit_timer

// File: test/pmbus_host_model.sv
// host model: bit-level management bus master driving the clock and data pins
module pmbus_host_model (
  // clock
  input  wire logic clk_i,
  // bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line reads high through its pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_o = 1'b1;
    tick(8);
    scl_o = 1'b1;
    tick(8);
    sda_o = 1'b0;
    tick(8);
    scl_o = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    tick(8);
    scl_o = 1'b1;
    tick(8);
    sda_o = 1'b1;
    tick(8);
  endtask
  // data moves only while the clock is low, two cycles after it falls, a cycle before the device lets go of its ack
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    tick(8);
    scl_o = 1'b1;
    tick(8);
    r = sda_i;
    scl_o = 1'b0;
    tick(2);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(1'b1, r);
  endtask
endmodule // pmbus_host_model

// File: test/current_fault_response_ctrl_chk.sv
// checker: port-level assertions for the undercurrent fault response controller
module current_fault_response_ctrl_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // bus and alert pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic alert_out_n_o,
  input wire logic alert_out_n_oe_n_o,
  // power stage
  input wire logic uc_fault_i,
  input wire logic output_on_i,
  input wire logic other_fault_i,
  input wire logic output_enable_o
);
  // cycles since the fault input / the output command were last seen active / low
  logic [3:0] flt_age_q;
  logic [3:0] on_age_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) flt_age_q <= 4'hf;
    else if (uc_fault_i) flt_age_q <= 4'h0;
    else if (flt_age_q != 4'hf) flt_age_q <= flt_age_q + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i || !output_on_i) on_age_q <= 4'h0;
    else if (on_age_q != 4'hf) on_age_q <= on_age_q + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence fault_rise;
    $rose(uc_fault_i) ##1 uc_fault_i;
  endsequence
  AST_RESET_QUIET: assert property (disable iff (1'b0) reset_i |=>
    alert_out_n_oe_n_o && sda_oe_n_o && !output_enable_o) else $error("outputs not idle after reset");
  AST_PIN_LOW_VAL: assert property (!sda_o && !alert_out_n_o) else $error("open drain value not low");
  AST_ALERT_ON_FAULT: assert property (fault_rise |-> ##[0:6] !alert_out_n_oe_n_o)
    else $error("fault did not pull alert low");
  AST_ALERT_CAUSE: assert property ($fell(alert_out_n_oe_n_o) |-> flt_age_q < 4'h8)
    else $error("alert without a fault");
  AST_ACK_SET: assert property ($fell(sda_oe_n_o) |-> !scl_i) else $error("data pulled while clock high");
  AST_ACK_REL: assert property ($rose(sda_oe_n_o) |-> !scl_i) else $error("data released while clock high");
  AST_OFF_CAUSE: assert property ($fell(output_enable_o) |-> flt_age_q < 4'h8 || on_age_q < 4'h8)
    else $error("output dropped without cause");
  AST_ON_CAUSE: assert property ($rose(output_enable_o) |-> on_age_q > 4'h1)
    else $error("output enabled while commanded off");
endmodule // current_fault_response_ctrl_chk

// File: test/test_current_fault_response_ctrl.sv
// testbench: drives the controller through its bus and power stage pins
module test_current_fault_response_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] cfg;
    int         olo, ohi, glo, ghi, rlo, rhi;
    logic       gone;
  } row_type;
  localparam logic [6:0] DEV = uc_fault_pkg::DEV_ADDR_DEFAULT;
  logic       clk      = 1'b0;
  logic       reset    = 1'b1;
  logic       uc_fault = 1'b0;
  logic       out_on   = 1'b0;
  logic       other    = 1'b0;
  logic       scl, host_sda, sda_o, sda_oe_n, alert_n, alert_oe_n, out_en;
  logic [7:0] d;
  wire        sda_w    = host_sda & (sda_oe_n | sda_o);
  int         miscompares = 0;
  int         cmp_count   = 0;
  // first off, retry gap, restarts, output after the fault goes
  row_type rows[8] = '{'{8'h00, -1, -1, -1, -1, 0, 0, 1'b1}, '{8'h43, 60, 70, -1, -1, 0, 0, 1'b0},
    '{8'h49, 20, 30, 16, 24, 1, 1, 1'b0}, '{8'h92, 0, 8, 32, 40, 2, 2, 1'b0},
    '{8'h92, 0, 8, 32, 40, 2, 2, 1'b0}, '{8'hb9, 0, 8, 16, 24, 8, 16, 1'b1},
    '{8'hc0, 0, 8, -1, -1, 0, 0, 1'b1}, '{8'h85, 0, 8, -1, -1, 0, 0, 1'b0}};
  initial begin
    forever #5 clk = ~clk;
  end
  current_fault_response_ctrl #(.CONT_UNIT_CYCLES(20), .RETRY_UNIT_CYCLES(16)) current_fault_response_ctrl_inst (
    .clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .alert_out_n_o(alert_n), .alert_out_n_oe_n_o(alert_oe_n), .uc_fault_i(uc_fault), .output_on_i(out_on),
    .other_fault_i(other), .output_enable_o(out_en));
  pmbus_host_model pmbus_host_model_inst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic tick(input int n);
    pmbus_host_model_inst.tick(n);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  // exp holds the acks of address, command and data byte
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] data, input logic [2:0] exp);
    logic [2:0] k;
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.put({a, 1'b0}, k[2]);
    pmbus_host_model_inst.put(cmd, k[1]);
    pmbus_host_model_inst.put(data, k[0]);
    pmbus_host_model_inst.stop();
    chk({5'h0, k}, {5'h0, exp});
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    logic k;
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.put({DEV, 1'b0}, k);
    pmbus_host_model_inst.put(cmd, k);
    pmbus_host_model_inst.start();
    pmbus_host_model_inst.put({DEV, 1'b1}, k);
    pmbus_host_model_inst.get(data);
    pmbus_host_model_inst.stop();
  endtask
  // holds the fault and times the output's reaction over its first 250 cycles
  task automatic run_row(input row_type r);
    int   t, first_off, gap, rises;
    logic prev;
    first_off = -1;
    gap = -1;
    rises = 0;
    prev = 1'b1;
    wr(DEV, 8'h7b, 8'h10, 3'b111);
    wr(DEV, 8'he6, r.cfg, 3'b111);
    tick(10);
    chk({7'h0, out_en}, 8'h01);
    uc_fault = 1'b1;
    for (t = 0; t < 250; t++) begin
      tick(1);
      if (!out_en && first_off < 0) first_off = t;
      if (out_en && !prev) begin
        rises++;
        if (gap < 0) gap = t - first_off;
      end
      prev = out_en;
    end
    rng(first_off, r.olo, r.ohi);
    rng(gap, r.glo, r.ghi);
    rng(rises, r.rlo, r.rhi);
    chk({7'h0, alert_oe_n}, 8'h00);
    rd(8'h7b, d);
    chk(d & 8'h10, 8'h10);
    uc_fault = 1'b0;
    tick(40);
    chk({7'h0, out_en}, {7'h0, r.gone});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    tick(5);
    chk({7'h0, alert_oe_n}, 8'h01);
    rd(8'he6, d);
    chk(d, uc_fault_pkg::UC_RESPONSE_RESET);
    wr(DEV, 8'he6, 8'h5b, 3'b111);
    wr(7'h21, 8'he6, 8'h00, 3'b000);
    wr(DEV, 8'h10, 8'h00, 3'b100);
    rd(8'he6, d);
    chk(d, 8'h5b);
    out_on = 1'b1;
    foreach (rows[i]) run_row(rows[i]);
    // another fault during a retry wait ends unlimited retries
    wr(DEV, 8'h7b, 8'h10, 3'b111);
    wr(DEV, 8'he6, 8'hb9, 3'b111);
    uc_fault = 1'b1;
    tick(30);
    other = 1'b1;
    tick(30);
    other = 1'b0;
    uc_fault = 1'b0;
    tick(60);
    chk({7'h0, out_en}, 8'h00);
    wr(DEV, 8'h7b, 8'h10, 3'b111);
    uc_fault = 1'b1;
    tick(30);
    out_on = 1'b0;
    tick(10);
    chk({7'h0, out_en}, 8'h00);
    uc_fault = 1'b0;
    out_on = 1'b1;
    tick(60);
    chk({7'h0, out_en}, 8'h01);
    wr(DEV, 8'h7b, 8'h10, 3'b111);
    tick(10);
    chk({7'h0, alert_oe_n}, 8'h01);
    wrap_up();
  end
  // a hung run counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule // test_current_fault_response_ctrl
bind current_fault_response_ctrl current_fault_response_ctrl_chk current_fault_response_ctrl_chk_inst (
  .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .alert_out_n_o(alert_out_n_o), .alert_out_n_oe_n_o(alert_out_n_oe_n_o), .uc_fault_i(uc_fault_i),
  .output_on_i(output_on_i), .other_fault_i(other_fault_i), .output_enable_o(output_enable_o));
